// *** bench/isac_bus_master.sv ***
/*
  bench model of an outside bus master that works the scl/sda pins.
  assumes the bench resolves both open-drain lines, with pull-ups, from all enables.
*/
`timescale 1ns/1ps
module isac_bus_master (
  input  wire logic clk_i,
  input  wire logic scl_i,
  input  wire logic sda_i,
  output logic      scl_low_o,
  output logic      sda_low_o
);
  logic smp;
  initial begin
    scl_low_o = 1'b0;
    sda_low_o = 1'b0;
  end
  task automatic hw(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  // start and restart: sda falls while scl high; scl parks low after
  task automatic start_c;
    sda_low_o = 1'b0;
    hw(5);
    scl_low_o = 1'b0;
    hw(10);
    sda_low_o = 1'b1;
    hw(10);
    scl_low_o = 1'b1;
  endtask
  // bounded wait on scl: the slave may stretch, but a hang must not stall the run
  task automatic bit_c(input logic b);
    sda_low_o = !b;
    hw(10);
    scl_low_o = 1'b0;
    for (int k = 0; k < 400 && !scl_i; k++) @(posedge clk_i);
    hw(10);
    smp = sda_i;
    scl_low_o = 1'b1;
  endtask
  // msb first, then a released ninth bit for the ack
  task automatic byte_c(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) bit_c(b[i]);
    bit_c(1'b1);
    ack = !smp;
  endtask
  task automatic stop_c;
    sda_low_o = 1'b1;
    hw(10);
    scl_low_o = 1'b0;
    hw(10);
    sda_low_o = 1'b0;
    hw(10);
  endtask
endmodule

// *** bench/tb_top.sv ***
/*
  self-checking bench: address matching, stretch, status flags, collisions.
  assumes isac_core with the bus master model on the pins.
*/
`timescale 1ns/1ps
module tb_top;
  import isac_pkg::*;
  logic clk_i, rst_n_i, link_clk_i, scl_oe, sda_oe, ms, md, en, ten, strict, rel, sclr, bclr;
  logic ss, ps, dna, dir, tbm, crb, sif, bcf, cirq, ack, msda, mscl, scl_dv, sda_dv;
  logic [ADDR_W-1:0] own, msk;
  logic [3:0] cmd, cmd_acc;
  logic [9:0] irq_n;
  isac_mst_phase_type ph;
  int mismatches, total_checks;
  isac_mst_phase_type phs [4] = '{MP_BITS, MP_START, MP_RSTART, MP_STOP};
  wire scl_w = !(ms | scl_oe);
  wire sda_w = !(md | sda_oe);
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = !clk_i;
  end
  initial begin
    link_clk_i = 1'b0;
    #37;
    forever #62.5 link_clk_i = !link_clk_i;
  end
  isac_bus_master m (.clk_i(clk_i), .scl_i(scl_w), .sda_i(sda_w), .scl_low_o(ms),
    .sda_low_o(md));
  isac_core dut_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .link_clk_i(link_clk_i), .scl_i(scl_w),
    .sda_i(sda_w), .scl_o(scl_dv), .scl_oe_o(scl_oe), .sda_o(sda_dv), .sda_oe_o(sda_oe),
    .module_enable_i(en), .ten_bit_addr_select_i(ten), .strict_reserved_i(strict),
    .own_address_reg_i(own), .address_mask_reg_i(msk), .clock_release_set_i(rel),
    .slave_irq_clear_i(sclr), .bus_collision_clear_i(bclr), .mst_phase_i(ph),
    .mst_sda_low_i(msda), .mst_scl_low_i(mscl), .start_seen_o(ss), .stop_seen_o(ps),
    .data_not_addr_o(dna), .direction_o(dir), .ten_bit_matched_flag_o(tbm),
    .clock_release_bit_o(crb), .slave_interrupt_flag_o(sif), .bus_collision_flag_o(bcf),
    .collision_irq_o(cirq), .cmd_clear_o(cmd));
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      cmd_acc <= 4'h0;
      irq_n   <= 10'h000;
    end else begin
      cmd_acc <= cmd_acc | cmd;
      irq_n   <= irq_n + {9'h000, cirq};
    end
  end
  task automatic chk(input logic [9:0] s, input logic [9:0] e);
    total_checks++;
    if (s !== e) begin
      mismatches++;
      $display("Error t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic pulse(ref logic p);
    p = 1'b1;
    m.hw(1);
    p = 1'b0;
    m.hw(10);
  endtask
  // one address byte, its ack and the flags it leaves
  task automatic adr(input logic [7:0] b, input logic ea);
    logic ed;
    // a second 10-bit byte carries no direction bit
    ed = b[0] && (!ten || b[7:3] == TEN_HDR);
    m.byte_c(b, ack);
    m.hw(10);
    chk({9'h000, ack}, {9'h000, ea});
    if (ea) chk({7'h00, dna, dir, sif}, {7'h00, 1'b0, ed, 1'b1});
    pulse(sclr);
  endtask
  task automatic unstretch;
    m.scl_low_o = 1'b0;
    m.hw(10);
    chk({8'h00, crb, scl_w}, 10'h000);
    pulse(rel);
    chk({9'h000, scl_w}, 10'h001);
  endtask
  task automatic end_sim;
    $display("checks=%0d mismatches=%0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    #2000000;
    mismatches++;
    end_sim;
  end
  initial begin
    {rst_n_i, ten, strict, rel, sclr, bclr, msda, mscl} = '0;
    {en, own, msk} = {1'b1, 10'h055, 10'h000};
    ph = MP_IDLE;
    repeat (8) @(posedge clk_i);
    #1 rst_n_i = 1'b1;
    m.hw(20);
    chk({5'h00, scl_dv, sda_dv, ss, ps, crb}, 10'h001);
    m.start_c; // idle bus confirmed just above
    m.hw(10);
    chk({8'h00, ss, ps}, 10'h002);
    adr(8'haa, 1'b1);
    m.stop_c;
    chk({8'h00, ss, ps}, 10'h001);
    msk = 10'h003;
    m.hw(20);
    m.start_c;
    adr(8'had, 1'b1);
    unstretch;
    m.stop_c;
    msk = 10'h000;
    m.start_c;
    adr(8'ha8, 1'b0);
    adr(8'haa, 1'b0);
    m.stop_c;
    for (int s = 0; s < 2; s++) begin
      {strict, msk} = {s[0], 10'h07f};
      m.hw(20);
      m.start_c;
      adr(8'hf0, !s[0]);
      m.stop_c;
    end
    {strict, ten, own, msk} = {1'b0, 1'b1, 10'h2a5, 10'h000};
    m.hw(20);
    m.start_c;
    adr(8'hf4, 1'b1);
    adr(8'ha5, 1'b1);
    chk({9'h000, tbm}, 10'h001);
    m.start_c;
    adr(8'hf5, 1'b1);
    unstretch;
    m.stop_c;
    for (int j = 0; j < 4; j++) begin
      ph = phs[j];
      msda = 1'b1;
      m.hw(10);
      chk({8'h00, sda_oe, scl_oe}, 10'h002);
      // our engine lets go while the other master pulls sda low
      msda = 1'b0;
      m.sda_low_o = 1'b1;
      m.hw(30);
      {msda, mscl} = 2'b11;
      m.hw(10);
      chk({8'h00, sda_oe, scl_oe}, 10'h000);
      chk({5'h00, bcf, cmd_acc}, {5'h01, 4'((1 << j) - 1)});
      chk(irq_n, 10'(j + 1));
      ph = MP_IDLE;
      {msda, mscl} = 2'b00;
      m.sda_low_o = 1'b0;
      m.hw(10);
      pulse(bclr);
    end
    en = 1'b0;
    m.hw(40);
    chk({8'h00, ss, ps}, 10'h000);
    end_sim;
  end
endmodule

// *** core/isac_arbiter.sv ***
/*
  arbitration monitor for the master side, on the link clock.
  assumes the master engine reports its phase and its own low drives on the link clock.
*/
`timescale 1ns/1ps
module isac_arbiter import isac_pkg::*; #(
  parameter logic [3:0] SETTLE = ARB_SETTLE
) (
  input  wire logic               clk_i,
  input  wire logic               rst_n_i,
  input  wire logic               en_i,
  input  isac_mst_phase_type      phase_i,
  input  wire logic               mst_sda_low_i,
  input  wire logic               scl_lvl_i,
  input  wire logic               sda_lvl_i,
  output logic                    abort_o,
  output logic                    coll_tgl_o,
  output isac_mst_phase_type      coll_phase_o
);
  typedef struct packed {
    logic [3:0]         cnt;
    logic               abort;
    logic               tgl;
    isac_mst_phase_type phase;
  } isac_arb_type;

  isac_arb_type ff;
  isac_arb_type nxt_ff;
  logic         mis;
  localparam logic [3:0] SETTLE_M1 = SETTLE - 4'h1;

  // released sda seen low while scl high; sampled levels lag the drive, so it must persist
  assign mis = en_i && (phase_i != MP_IDLE) && !mst_sda_low_i && scl_lvl_i
               && !sda_lvl_i && !ff.abort;

  always_comb begin
    nxt_ff     = ff;
    nxt_ff.cnt = mis ? ff.cnt + 4'h1 : 4'h0;
    if (mis && ff.cnt == SETTLE_M1) begin
      nxt_ff.abort = 1'b1;
      nxt_ff.tgl   = ~ff.tgl;
      nxt_ff.phase = phase_i;
      nxt_ff.cnt   = 4'h0;
    end else if (ff.abort && (phase_i == MP_IDLE || !en_i)) begin
      nxt_ff.abort = 1'b0;  // master has gone idle or the monitor is disabled
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ff <= '{cnt: 4'h0, abort: 1'b0, tgl: 1'b0, phase: MP_IDLE};
    end else begin
      ff <= nxt_ff;
    end
  end

  assign abort_o      = ff.abort;
  assign coll_tgl_o   = ff.tgl;
  assign coll_phase_o = ff.phase;

  property p_coll(isac_mst_phase_type ph);
    @(posedge clk_i) disable iff (!rst_n_i)
    (mis && ff.cnt == SETTLE_M1 && phase_i == ph) |=> ff.abort && ff.phase == ph && $changed(ff.tgl);
  endproperty

  a_coll_start:  assert property (p_coll(MP_START))  else $error("start collision missed");
  a_coll_rstart: assert property (p_coll(MP_RSTART)) else $error("restart collision missed");
  a_coll_bits:   assert property (p_coll(MP_BITS))   else $error("bit collision missed");
  a_coll_stop:   assert property (p_coll(MP_STOP))   else $error("stop collision missed");
  a_abort_held:  assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $rose(ff.abort) |-> $past(mis) && $past(ff.cnt) == SETTLE_M1) else $error("abort without cause");
endmodule

// *** core/isac_core.sv ***
/*
  two-wire slave address detector with start/stop status and master collision reporting.
  assumes software ports on clk_i, pins and master engine on link_clk_i; data bytes handled elsewhere.
*/
`timescale 1ns/1ps
module isac_core import isac_pkg::*; (
  input  wire logic              clk_i,
  input  wire logic              rst_n_i,
  input  wire logic              link_clk_i,
  input  wire logic              scl_i,
  input  wire logic              sda_i,
  output logic                   scl_o,
  output logic                   scl_oe_o,
  output logic                   sda_o,
  output logic                   sda_oe_o,
  input  wire logic              module_enable_i,
  input  wire logic              ten_bit_addr_select_i,
  input  wire logic              strict_reserved_i,
  input  wire logic [ADDR_W-1:0] own_address_reg_i,
  input  wire logic [ADDR_W-1:0] address_mask_reg_i,
  input  wire logic              clock_release_set_i,
  input  wire logic              slave_irq_clear_i,
  input  wire logic              bus_collision_clear_i,
  input  isac_mst_phase_type     mst_phase_i,
  input  wire logic              mst_sda_low_i,
  input  wire logic              mst_scl_low_i,
  output logic                   start_seen_o,
  output logic                   stop_seen_o,
  output logic                   data_not_addr_o,
  output logic                   direction_o,
  output logic                   ten_bit_matched_flag_o,
  output logic                   clock_release_bit_o,
  output logic                   slave_interrupt_flag_o,
  output logic                   bus_collision_flag_o,
  output logic                   collision_irq_o,
  output logic [3:0]             cmd_clear_o
);
  typedef struct packed {
    isac_slv_state_type st;
    logic [7:0]         shift;
    logic [3:0]         bitcnt;
    logic               scl_lvl;
    logic               sda_lvl;
    logic               scl_oe;
    logic               sda_oe;
    logic               bus_scl_oe;
    logic               bus_sda_oe;
    logic               start_seen;
    logic               stop_seen;
    logic               dna;
    logic               dir;
    logic               tenm;
    logic               tendone;
    logic               rel;
    logic               rd;
    logic               slv_tgl;
    logic               cfg_ack;
    logic               rel_seen;
    logic               en;
    logic               ten;
    logic               strict;
    logic [ADDR_W-1:0]  own;
    logic [ADDR_W-1:0]  mask;
  } isac_link_type;

  typedef struct packed {
    logic              cfg_req;
    logic              cfg_busy;
    logic              en;
    logic              ten;
    logic              strict;
    logic [ADDR_W-1:0] own;
    logic [ADDR_W-1:0] mask;
    logic              rel_tgl;
    logic              slv_seen;
    logic              coll_seen;
    logic              slv_flag;
    logic              coll_flag;
    logic              coll_irq;
    logic [3:0]        cmd_clr;
  } isac_sys_type;

  isac_link_type      l;
  isac_link_type      nxt_l;
  isac_sys_type       s;
  isac_sys_type       nxt_s;
  logic [1:0]         pin_q;
  logic [1:0]         pin_p;
  logic [1:0]         s2l;
  logic [8:0]         l2s;
  logic               scl_new;
  logic               sda_new;
  logic               rise;
  logic               fall;
  logic               start_det;
  logic               stop_det;
  logic               rsv;
  logic               m7;
  logic               m10a;
  logic               m10b;
  logic               addr_ok;
  logic               arb_abort;
  logic               arb_tgl;
  isac_mst_phase_type arb_phase;

  // pins pass three flops; a change counts once the last two agree
  isac_sync #(.W(2), .N(PIN_STAGES)) u_pin (
    .clk_i   (link_clk_i),
    .rst_n_i (rst_n_i),
    .d_i     ({scl_i, sda_i}),
    .q_o     (pin_q),
    .qp_o    (pin_p)
  );

  isac_sync #(.W(2), .N(LVL_STAGES)) u_s2l (
    .clk_i   (link_clk_i),
    .rst_n_i (rst_n_i),
    .d_i     ({s.rel_tgl, s.cfg_req}),
    .q_o     (s2l),
    .qp_o    ()
  );

  isac_sync #(.W(9), .N(LVL_STAGES)) u_l2s (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .d_i     ({l.cfg_ack, arb_tgl, l.slv_tgl, l.rel, l.tenm, l.dir, l.dna,
               l.stop_seen, l.start_seen}),
    .q_o     (l2s),
    .qp_o    ()
  );

  isac_arbiter u_arb (
    .clk_i         (link_clk_i),
    .rst_n_i       (rst_n_i),
    .en_i          (l.en),
    .phase_i       (mst_phase_i),
    .mst_sda_low_i (mst_sda_low_i),
    .scl_lvl_i     (l.scl_lvl),
    .sda_lvl_i     (l.sda_lvl),
    .abort_o       (arb_abort),
    .coll_tgl_o    (arb_tgl),
    .coll_phase_o  (arb_phase)
  );

  assign scl_new   = (pin_q[1] == pin_p[1]) ? pin_q[1] : l.scl_lvl;
  assign sda_new   = (pin_q[0] == pin_p[0]) ? pin_q[0] : l.sda_lvl;
  assign rise      = scl_new && !l.scl_lvl;
  assign fall      = !scl_new && l.scl_lvl;
  assign start_det = l.scl_lvl && scl_new && l.sda_lvl && !sda_new;
  assign stop_det  = l.scl_lvl && scl_new && !l.sda_lvl && sda_new;
  assign rsv       = (l.shift[7:4] == RSV_LOW) || (l.shift[7:4] == RSV_HIGH);
  // mask bit set means either value of that address bit matches
  assign m7   = (((l.shift[7:1] ^ l.own[6:0]) & ~l.mask[6:0]) == 7'h00)
                && !(l.strict && rsv);
  assign m10a = (l.shift[7:3] == TEN_HDR)
                && (((l.shift[2:1] ^ l.own[9:8]) & ~l.mask[9:8]) == 2'h0);
  assign m10b = ((l.shift ^ l.own[7:0]) & ~l.mask[7:0]) == 8'h00;
  // a read header is only accepted once the full 10-bit address has matched
  assign addr_ok = (l.st == SL_ADDR2) ? m10b :
                   l.ten ? (m10a && (!l.shift[0] || l.tendone)) : m7;

  always_comb begin
    nxt_l         = l;
    nxt_l.scl_lvl = scl_new;
    nxt_l.sda_lvl = sda_new;
    if (s2l[0] != l.cfg_ack) begin
      // hold fields are stable while the request toggle is outstanding
      nxt_l.cfg_ack = s2l[0];
      nxt_l.en      = s.en;
      nxt_l.ten     = s.ten;
      nxt_l.strict  = s.strict;
      nxt_l.own     = s.own;
      nxt_l.mask    = s.mask;
    end
    if (!l.en) begin
      nxt_l.st         = SL_IDLE;
      nxt_l.start_seen = 1'b0;
      nxt_l.stop_seen  = 1'b0;
      nxt_l.scl_oe     = 1'b0;
      nxt_l.sda_oe     = 1'b0;
      nxt_l.tendone    = 1'b0;
    end else if (start_det) begin
      nxt_l.st         = SL_ADDR1;
      nxt_l.bitcnt     = 4'h0;
      nxt_l.start_seen = 1'b1;
      nxt_l.stop_seen  = 1'b0;
      nxt_l.scl_oe     = 1'b0;
      nxt_l.sda_oe     = 1'b0;
    end else if (stop_det) begin
      nxt_l.st         = SL_IDLE;
      nxt_l.stop_seen  = 1'b1;
      nxt_l.start_seen = 1'b0;
      nxt_l.scl_oe     = 1'b0;
      nxt_l.sda_oe     = 1'b0;
      nxt_l.tendone    = 1'b0;
      nxt_l.tenm       = 1'b0;
    end else begin
      case (l.st)
        SL_ADDR1, SL_ADDR2: begin
          if (rise) begin
            nxt_l.shift  = {l.shift[6:0], sda_new};
            nxt_l.bitcnt = l.bitcnt + 4'h1;
          end else if (fall && l.bitcnt == BYTE_BITS) begin
            if (addr_ok) begin
              nxt_l.sda_oe = 1'b1;
              nxt_l.rd     = (l.st == SL_ADDR1) && l.shift[0];
              nxt_l.st     = (l.st == SL_ADDR1) ? SL_ACK1 : SL_ACK2;
            end else begin
              nxt_l.st = SL_IDLE;
            end
          end
        end
        SL_ACK1: begin
          if (fall) begin
            nxt_l.sda_oe  = 1'b0;
            nxt_l.slv_tgl = ~l.slv_tgl;
            nxt_l.dna     = 1'b0;
            nxt_l.dir     = l.rd;
            nxt_l.bitcnt  = 4'h0;
            if (l.rd) begin
              nxt_l.rel    = 1'b0;
              nxt_l.scl_oe = 1'b1;
              nxt_l.st     = SL_HOLD;
            end else if (l.ten) begin
              nxt_l.st = SL_ADDR2;
            end else begin
              nxt_l.st = SL_DATA;
            end
          end
        end
        SL_ACK2: begin
          if (fall) begin
            nxt_l.sda_oe  = 1'b0;
            nxt_l.slv_tgl = ~l.slv_tgl;
            nxt_l.dna     = 1'b0;
            nxt_l.dir     = 1'b0;
            nxt_l.tenm    = 1'b1;
            nxt_l.tendone = 1'b1;
            nxt_l.bitcnt  = 4'h0;
            nxt_l.st      = SL_DATA;
          end
        end
        SL_HOLD: begin
          if (l.rel) begin
            nxt_l.scl_oe = 1'b0;
            nxt_l.st     = SL_DATA;
          end
        end
        SL_DATA: begin
          // only tracks byte boundaries; payload moves in another block
          if (rise) begin
            nxt_l.bitcnt = (l.bitcnt == ACK_BIT) ? 4'h1 : l.bitcnt + 4'h1;
            if (l.bitcnt == BYTE_BITS - 4'h1) begin
              nxt_l.dna = 1'b1;
            end
          end
        end
        default: begin
          nxt_l.st = SL_IDLE;
        end
      endcase
    end
    if (s2l[1] != l.rel_seen) begin
      nxt_l.rel_seen = s2l[1];
      nxt_l.rel      = 1'b1;
    end
    // an aborted master lets go of both lines at once
    nxt_l.bus_sda_oe = nxt_l.sda_oe || (mst_sda_low_i && !arb_abort);
    nxt_l.bus_scl_oe = nxt_l.scl_oe || (mst_scl_low_i && !arb_abort);
  end

  always_ff @(posedge link_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      l         <= '0;
      l.st      <= SL_IDLE;
      l.scl_lvl <= 1'b1;
      l.sda_lvl <= 1'b1;
      l.rel     <= 1'b1;
    end else begin
      l <= nxt_l;
    end
  end

  always_comb begin
    nxt_s         = s;
    nxt_s.coll_irq = 1'b0;
    nxt_s.cmd_clr = 4'h0;
    if (!s.cfg_busy && {module_enable_i, ten_bit_addr_select_i, strict_reserved_i,
        own_address_reg_i, address_mask_reg_i} != {s.en, s.ten, s.strict, s.own, s.mask}) begin
      nxt_s.en       = module_enable_i;
      nxt_s.ten      = ten_bit_addr_select_i;
      nxt_s.strict   = strict_reserved_i;
      nxt_s.own      = own_address_reg_i;
      nxt_s.mask     = address_mask_reg_i;
      nxt_s.cfg_req  = ~s.cfg_req;
      nxt_s.cfg_busy = 1'b1;
    end else if (s.cfg_busy && l2s[8] == s.cfg_req) begin
      nxt_s.cfg_busy = 1'b0;
    end
    if (clock_release_set_i) begin
      nxt_s.rel_tgl = ~s.rel_tgl;
    end
    // clears first so that a same-cycle event still sets
    if (slave_irq_clear_i) begin
      nxt_s.slv_flag = 1'b0;
    end
    if (bus_collision_clear_i) begin
      nxt_s.coll_flag = 1'b0;
    end
    if (l2s[6] != s.slv_seen) begin
      nxt_s.slv_seen = l2s[6];
      nxt_s.slv_flag = 1'b1;
    end
    if (l2s[7] != s.coll_seen) begin
      nxt_s.coll_seen = l2s[7];
      nxt_s.coll_flag = 1'b1;
      nxt_s.coll_irq  = 1'b1;
      nxt_s.cmd_clr[CLR_START]  = (arb_phase == MP_START);
      nxt_s.cmd_clr[CLR_RSTART] = (arb_phase == MP_RSTART);
      nxt_s.cmd_clr[CLR_STOP]   = (arb_phase == MP_STOP);
      nxt_s.cmd_clr[CLR_ACK]    = (arb_phase == MP_ACK);
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s <= '0;
    end else begin
      s <= nxt_s;
    end
  end

  assign scl_o                  = 1'b0;
  assign sda_o                  = 1'b0;
  assign scl_oe_o               = l.bus_scl_oe;
  assign sda_oe_o               = l.bus_sda_oe;
  assign start_seen_o           = l2s[0];
  assign stop_seen_o            = l2s[1];
  assign data_not_addr_o        = l2s[2];
  assign direction_o            = l2s[3];
  assign ten_bit_matched_flag_o = l2s[4];
  assign clock_release_bit_o    = l2s[5];
  assign slave_interrupt_flag_o = s.slv_flag;
  assign bus_collision_flag_o   = s.coll_flag;
  assign collision_irq_o        = s.coll_irq;
  assign cmd_clear_o            = s.cmd_clr;

  default clocking cb @(posedge link_clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_byte_end(isac_slv_state_type ph);
    l.en && !start_det && !stop_det && l.st == ph && fall && l.bitcnt == BYTE_BITS;
  endsequence
  sequence s_ack1_end;
    l.en && !start_det && !stop_det && l.st == SL_ACK1 && fall && s2l[1] == l.rel_seen;
  endsequence

  a_start_flags: assert property (l.en && start_det |=> l.start_seen && !l.stop_seen
    && l.st == SL_ADDR1) else $error("start flags wrong");
  a_stop_flags: assert property (l.en && stop_det |=> l.stop_seen && !l.start_seen)
    else $error("stop flags wrong");
  a_disable_clr: assert property (!l.en |=> !l.start_seen && !l.stop_seen && l.st == SL_IDLE)
    else $error("disabled slave not idle");
  a_idle_quiet: assert property (l.st == SL_IDLE |-> !l.sda_oe && !l.scl_oe)
    else $error("idle slave drives bus");
  a_rise_sample: assert property (l.en && !start_det && !stop_det && l.st == SL_ADDR1 && rise
    |=> l.shift[0] == $past(sda_new) && l.bitcnt == $past(l.bitcnt) + 4'h1)
    else $error("bit not taken on scl rise");
  a_ack_seven: assert property (s_byte_end(SL_ADDR1) ##0 !l.ten && !(l.strict && rsv)
    && ((l.shift[7:1] ^ l.own[6:0]) & ~l.mask[6:0]) == 7'h00 |=> l.sda_oe && l.st == SL_ACK1)
    else $error("7-bit match not acked");
  a_strict_rsv: assert property (s_byte_end(SL_ADDR1) ##0 !l.ten && l.strict && rsv
    |=> l.st == SL_IDLE && !l.sda_oe) else $error("reserved address acked");
  a_write_irq: assert property (s_ack1_end ##0 !l.rd |=> $changed(l.slv_tgl) && !l.dir
    && !l.dna && !l.sda_oe) else $error("write match event wrong");
  a_read_hold: assert property (s_ack1_end ##0 l.rd |=> l.scl_oe && !l.rel && l.dir
    ##1 l.bus_scl_oe) else $error("read match not stretched");
  a_ten_header: assert property (s_byte_end(SL_ADDR1) ##0 l.ten && l.shift[7:3] != TEN_HDR
    |=> l.st == SL_IDLE) else $error("bad 10-bit header accepted");
  a_ten_next: assert property (s_ack1_end ##0 l.ten && !l.rd |=> l.st == SL_ADDR2)
    else $error("second address byte skipped");
  a_ten_second: assert property (l.en && !start_det && !stop_det && l.st == SL_ACK2 && fall
    |=> l.tenm && l.st == SL_DATA && !l.sda_oe) else $error("10-bit match flag missing");
  a_ten_restart: assert property (s_byte_end(SL_ADDR1) ##0 l.ten && l.tendone && m10a
    && l.shift[0] |=> l.st == SL_ACK1 && l.rd) else $error("restart read not matched");
endmodule

// *** core/isac_pkg.sv ***
/*
  shared constants and state types for the two-wire slave address matcher and
  the master arbitration monitor.
  assumes the scl/sda pins arrive asynchronously and that software-side ports sit on clk_i.
*/
package isac_pkg;
  localparam int unsigned ADDR_W      = 10;
  localparam int unsigned PIN_STAGES  = 3;
  localparam int unsigned LVL_STAGES  = 2;
  localparam logic [3:0]  BYTE_BITS   = 4'h8;
  localparam logic [3:0]  ACK_BIT     = 4'h9;
  localparam logic [4:0]  TEN_HDR     = 5'h1e;
  localparam logic [3:0]  RSV_LOW     = 4'h0;
  localparam logic [3:0]  RSV_HIGH    = 4'hf;
  localparam logic [3:0]  ARB_SETTLE  = 4'h6;
  localparam int unsigned CLR_START   = 0;
  localparam int unsigned CLR_RSTART  = 1;
  localparam int unsigned CLR_STOP    = 2;
  localparam int unsigned CLR_ACK     = 3;

  typedef enum logic [6:0] {
    SL_IDLE  = 7'h01,
    SL_ADDR1 = 7'h02,
    SL_ACK1  = 7'h04,
    SL_ADDR2 = 7'h08,
    SL_ACK2  = 7'h10,
    SL_HOLD  = 7'h20,
    SL_DATA  = 7'h40
  } isac_slv_state_type;

  typedef enum logic [5:0] {
    MP_IDLE   = 6'h01,
    MP_START  = 6'h02,
    MP_RSTART = 6'h04,
    MP_BITS   = 6'h08,
    MP_ACK    = 6'h10,
    MP_STOP   = 6'h20
  } isac_mst_phase_type;
endpackage

// *** core/isac_sync.sv ***
/*
  multi-stage synchroniser for a group of independent level bits.
  assumes each bit changes slowly compared with the destination clock.
*/
`timescale 1ns/1ps
module isac_sync import isac_pkg::*; #(
  parameter int unsigned W = 1,
  parameter int unsigned N = 2
) (
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o,
  output logic      [W-1:0] qp_o
);
  typedef struct packed {
    logic [N-1:0][W-1:0] st;
  } isac_sync_type;

  isac_sync_type ff;
  isac_sync_type nxt_ff;

  // the first stage feeds the second one, and also qp_o when N is 2
  always_comb begin
    nxt_ff    = ff;
    nxt_ff.st = {ff.st[N-2:0], d_i};
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ff <= '0;
    end else begin
      ff <= nxt_ff;
    end
  end

  assign q_o  = ff.st[N-1];
  assign qp_o = ff.st[N-2];
endmodule
